/* hw/rmc_top.sv */
// radio mode state machine with AXI4-Lite register access
// assumes modem and fifo strobes on sys_clk; activate, select and rf detect pins are async
//
// Implementation choices: register access over AXI4-Lite and the address map.
`default_nettype none
module rmc_top #(
  parameter int unsigned CD_CYC_P    = rmc_pkg::CD_CYC,
  parameter int unsigned ACK_CYC_P   = rmc_pkg::ACK_WAIT_CYC,
  parameter int unsigned RSTEP_CYC_P = rmc_pkg::RETRY_STEP_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              radio_activate,
  input  wire logic              spi_select_n,
  input  wire logic              rf_signal,
  input  wire logic              tx_fifo_empty,
  input  wire logic              tx_no_ack,
  input  wire logic              tx_done,
  input  wire logic              ack_received,
  input  wire logic              rx_pkt_valid,
  input  wire logic              rx_addr_match,
  input  wire logic              rx_crc_ok,
  input  wire logic              rx_no_ack,
  input  wire logic              rx_fifo_full,
  output logic                   tx_on,
  output logic                   rx_on,
  output logic                   tx_start,
  output logic                   tx_retransmit,
  output logic                   tx_is_ack,
  output logic                   rx_write,
  output logic [11:0]            carrier_freq_mhz,
  output rmc_pkg::rmc_rate_t     air_rate,
  output rmc_pkg::rmc_state_t    mode,
  output logic                   irq_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import rmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic       ce;
  logic       sel_active;
  logic       rf_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q <= 3'h2;
      pin_sync_q <= 3'h2;
    end else begin
      pin_meta_q <= {rf_signal, spi_select_n, radio_activate};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign ce         = pin_sync_q[0];
  assign sel_active = ~pin_sync_q[1];
  assign rf_s       = pin_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  rmc_ctrl_t   ctrl_q;
  logic [3:0]  limit_q;
  logic [3:0]  delay_q;
  logic [6:0]  channel_q;
  rmc_flags_t  flags_q;
  rmc_flags_t  mask_q;
  rmc_flags_t  flag_set;
  logic [7:0]  drops_q;
  rmc_state_t  state_q;
  logic [3:0]  rcnt_q;
  logic        cd_q;

  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic        wr_hit;

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_hit  = awaddr_q == OFF_CTRL || awaddr_q == OFF_RETRY || awaddr_q == OFF_CHANNEL
                || awaddr_q == OFF_FLAGS || awaddr_q == OFF_MASK;

  // write channel: address and data are taken in either order, one write at a time
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // software registers stay writable in every mode, power down included
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= CTRL_RST;
      limit_q   <= LIMIT_RST;
      delay_q   <= DELAY_RST;
      channel_q <= CHANNEL_RST;
      mask_q    <= MASK_RST;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        OFF_CTRL:    ctrl_q    <= wdata_q[4:0];
        OFF_RETRY:   begin
          limit_q <= wdata_q[RT_LIM_LSB +: 4];
          delay_q <= wdata_q[RT_DLY_LSB +: 4];
        end
        OFF_CHANNEL: channel_q <= wdata_q[6:0];
        OFF_MASK:    mask_q    <= wdata_q[2:0];
        default:     ;
      endcase
    end
  end

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= 3'h0;
    end else begin
      if (wr_fire && wstrb_q[0] && awaddr_q == OFF_FLAGS) begin
        flags_q <= (flags_q & ~rmc_flags_t'(wdata_q[2:0])) | flag_set;
      end else begin
        flags_q <= flags_q | flag_set;
      end
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
      case ({s_axi_araddr[7:2], 2'b00})
        OFF_CTRL:    s_axi_rdata[4:0] <= ctrl_q;
        OFF_RETRY:   s_axi_rdata[7:0] <= {delay_q, limit_q};
        OFF_CHANNEL: s_axi_rdata[6:0] <= channel_q;
        OFF_STATUS:  begin
          s_axi_rdata[ST_STATE_LSB +: 3] <= state_q;
          s_axi_rdata[ST_RCNT_LSB +: 4]  <= rcnt_q;
          s_axi_rdata[ST_CD_BIT]         <= cd_q;
          s_axi_rdata[ST_SEL_BIT]        <= sel_active;
        end
        OFF_FLAGS:   s_axi_rdata[2:0] <= flags_q;
        OFF_MASK:    s_axi_rdata[2:0] <= mask_q;
        OFF_DROPS:   s_axi_rdata[7:0] <= drops_q;
        default:     s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  logic        aa;
  logic        ack_wait_q;
  logic        retry_pend_q;
  logic        pkt_ok;
  logic [15:0] tmr_q;
  logic [3:0]  steps_q;
  logic        ack_timeout;
  logic        retry_due;
  logic        can_retry;
  logic        tmr_run;

  assign aa          = ctrl_q.auto_ack_enable;
  assign pkt_ok      = rx_pkt_valid & rx_addr_match & rx_crc_ok;
  assign ack_timeout = ack_wait_q && tmr_q == 16'(ACK_CYC_P - 1);
  assign retry_due   = retry_pend_q && steps_q == delay_q && tmr_q == 16'(RSTEP_CYC_P - 1);
  assign can_retry   = rcnt_q < limit_q;
  assign tmr_run     = (ack_wait_q && state_q == RMC_RX)
                    || (retry_pend_q && state_q == RMC_STBY1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q       <= RMC_PWR_DOWN;
      ack_wait_q    <= 1'b0;
      retry_pend_q  <= 1'b0;
      rcnt_q        <= 4'h0;
      tx_start      <= 1'b0;
      tx_retransmit <= 1'b0;
      tx_is_ack     <= 1'b0;
      flag_set      <= 3'h0;
    end else begin
      tx_start <= 1'b0;
      flag_set <= 3'h0;
      if (!ctrl_q.power_on_bit) begin
        state_q      <= RMC_PWR_DOWN;
        ack_wait_q   <= 1'b0;
        retry_pend_q <= 1'b0;
      end else begin
        case (state_q)
          RMC_PWR_DOWN: state_q <= RMC_STBY1;
          RMC_STBY1: begin
            if (retry_pend_q) begin
              if (retry_due) begin
                retry_pend_q  <= 1'b0;
                state_q       <= RMC_TX;
                tx_start      <= 1'b1;
                tx_retransmit <= 1'b1;
                tx_is_ack     <= 1'b0;
              end
            end else if (ce && ctrl_q.receiver_role) begin
              state_q <= RMC_RX;
            end else if (ce && !tx_fifo_empty) begin
              state_q       <= RMC_TX;
              tx_start      <= 1'b1;
              tx_retransmit <= 1'b0;
              tx_is_ack     <= 1'b0;
              rcnt_q        <= 4'h0;
            end else if (ce) begin
              state_q <= RMC_STBY2;
            end
          end
          RMC_STBY2: begin
            if (!ce || ctrl_q.receiver_role) begin
              state_q <= RMC_STBY1;
            end else if (!tx_fifo_empty) begin
              state_q       <= RMC_TX;
              tx_start      <= 1'b1;
              tx_retransmit <= 1'b0;
              tx_is_ack     <= 1'b0;
              rcnt_q        <= 4'h0;
            end
          end
          // the packet on air always finishes before activate low is honoured
          RMC_TX: begin
            if (tx_done) begin
              if (tx_is_ack) begin
                state_q <= ce ? RMC_RX : RMC_STBY1;
              end else if (aa && !tx_no_ack) begin
                state_q    <= RMC_RX;
                ack_wait_q <= 1'b1;
              end else begin
                flag_set.tx_sent <= 1'b1;
                if (!ce) begin
                  state_q <= RMC_STBY1;
                end else if (!tx_fifo_empty) begin
                  tx_start      <= 1'b1;
                  tx_retransmit <= 1'b0;
                  rcnt_q        <= 4'h0;
                end else begin
                  state_q <= RMC_STBY2;
                end
              end
            end
          end
          RMC_RX: begin
            if (ack_wait_q) begin
              if (ack_received) begin
                ack_wait_q       <= 1'b0;
                flag_set.tx_sent <= 1'b1;
                state_q          <= ce ? RMC_STBY2 : RMC_STBY1;
              end else if (ack_timeout) begin
                ack_wait_q <= 1'b0;
                state_q    <= RMC_STBY1;
                if (can_retry) begin
                  retry_pend_q <= 1'b1;
                  rcnt_q       <= rcnt_q + 4'h1;
                end else begin
                  flag_set.max_retry <= 1'b1;
                end
              end
            end else if (!ce) begin
              state_q <= RMC_STBY1;
            end else if (pkt_ok && aa && !rx_no_ack) begin
              state_q       <= RMC_TX;
              tx_start      <= 1'b1;
              tx_retransmit <= 1'b0;
              tx_is_ack     <= 1'b1;
            end
          end
          default: state_q <= RMC_PWR_DOWN;
        endcase
      end
      if (pkt_ok && state_q == RMC_RX && !ack_wait_q && !rx_fifo_full) begin
        flag_set.rx_ready <= 1'b1;
      end
    end
  end

  // one timer serves the ack wait and the retry delay, which never overlap
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_q   <= 16'h0;
      steps_q <= 4'h0;
    end else if (!tmr_run) begin
      tmr_q   <= 16'h0;
      steps_q <= 4'h0;
    end else if (ack_wait_q ? ack_timeout : tmr_q == 16'(RSTEP_CYC_P - 1)) begin
      // the retry delay must count its steps from zero once the ack wait runs out
      tmr_q   <= 16'h0;
      steps_q <= ack_wait_q ? 4'h0 : steps_q + 4'h1;
    end else begin
      tmr_q <= tmr_q + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path and carrier detect
  logic [15:0] cd_cnt_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_write <= 1'b0;
      drops_q  <= 8'h00;
    end else begin
      rx_write <= 1'b0;
      if (pkt_ok && state_q == RMC_RX && !ack_wait_q) begin
        if (!rx_fifo_full) begin
          rx_write <= 1'b1;
        end else if (drops_q != 8'hff) begin
          drops_q <= drops_q + 8'h01;
        end
      end
    end
  end

  // a short burst of in-channel energy must not flag a busy channel
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cd_cnt_q <= 16'h0;
      cd_q     <= 1'b0;
    end else if (!rf_s || state_q != RMC_RX) begin
      cd_cnt_q <= 16'h0;
      cd_q     <= 1'b0;
    end else if (cd_cnt_q == 16'(CD_CYC_P - 1)) begin
      cd_q <= 1'b1;
    end else begin
      cd_cnt_q <= cd_cnt_q + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_on            <= 1'b0;
      rx_on            <= 1'b0;
      mode             <= RMC_PWR_DOWN;
      carrier_freq_mhz <= BASE_FREQ_MHZ;
      air_rate         <= RMC_RATE_1M;
      irq_n            <= 1'b1;
    end else begin
      tx_on            <= state_q == RMC_TX;
      rx_on            <= state_q == RMC_RX;
      mode             <= state_q;
      carrier_freq_mhz <= BASE_FREQ_MHZ + {5'h0, channel_q};
      if (ctrl_q.rate_low_sel) begin
        air_rate <= RMC_RATE_250K;
      end else begin
        air_rate <= ctrl_q.rate_high_sel ? RMC_RATE_2M : RMC_RATE_1M;
      end
      irq_n <= ~|(flags_q & ~mask_q);
    end
  end
endmodule
`default_nettype wire

/* shared/rmc_pkg.sv */
// constants and types of the radio mode state control block
// assumes a 100 MHz system clock; time figures are turned into cycle counts here
`default_nettype none
package rmc_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned CD_TIME_US     = 128;
  localparam int unsigned CD_CYC         = CD_TIME_US * CLK_MHZ;
  localparam int unsigned ACK_WAIT_US    = 250;
  localparam int unsigned ACK_WAIT_CYC   = ACK_WAIT_US * CLK_MHZ;
  localparam int unsigned RETRY_STEP_US  = 250;
  localparam int unsigned RETRY_STEP_CYC = RETRY_STEP_US * CLK_MHZ;
  localparam logic [11:0] BASE_FREQ_MHZ  = 12'h960;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_RETRY   = 8'h04;
  localparam logic [7:0] OFF_CHANNEL = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_FLAGS   = 8'h10;
  localparam logic [7:0] OFF_MASK    = 8'h14;
  localparam logic [7:0] OFF_DROPS   = 8'h18;

  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_RCNT_LSB  = 3;
  localparam int unsigned ST_CD_BIT    = 7;
  localparam int unsigned ST_SEL_BIT   = 8;
  localparam int unsigned RT_LIM_LSB   = 0;
  localparam int unsigned RT_DLY_LSB   = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RMC_PWR_DOWN, RMC_STBY1, RMC_STBY2, RMC_TX, RMC_RX
  } rmc_state_t;

  typedef enum logic [1:0] {RMC_RATE_1M, RMC_RATE_2M, RMC_RATE_250K} rmc_rate_t;

  typedef struct packed {
    logic rate_high_sel;
    logic rate_low_sel;
    logic auto_ack_enable;
    logic receiver_role;
    logic power_on_bit;
  } rmc_ctrl_t;

  typedef struct packed {
    logic max_retry;
    logic rx_ready;
    logic tx_sent;
  } rmc_flags_t;

  localparam rmc_ctrl_t  CTRL_RST    = 5'h04;
  localparam logic [3:0] LIMIT_RST   = 4'h3;
  localparam logic [3:0] DELAY_RST   = 4'h0;
  localparam logic [6:0] CHANNEL_RST = 7'h02;
  localparam rmc_flags_t MASK_RST    = 3'h0;
endpackage
`default_nettype wire

/* verification/rmc_chk.sv */
// assertions on mode machine outputs and register bus handshakes
// bound into rmc_top; sees its ports only, one clock domain
`default_nettype none
module rmc_chk (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                tx_on,
  input wire logic                rx_on,
  input wire logic                tx_start,
  input wire logic                rx_write,
  input wire logic                rx_pkt_valid,
  input wire logic                rx_addr_match,
  input wire logic                rx_crc_ok,
  input wire logic                rx_fifo_full,
  input wire rmc_pkg::rmc_state_t mode,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_arready
);
  import rmc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // start pulse leads the mode output by up to two cycles
  sequence enter_tx;
    ##[0:2] (mode == RMC_TX);
  endsequence
  sequence pulse_once;
    tx_start ##1 !tx_start;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_one_role: assert property (!(tx_on && rx_on))
    else $error("transmit and receive on together");
  chk_on_mode: assert property (tx_on == (mode == RMC_TX) && rx_on == (mode == RMC_RX))
    else $error("path enables disagree with mode");
  chk_pd_quiet: assert property (mode == RMC_PWR_DOWN |-> !tx_start && !rx_write)
    else $error("activity in power down");
  chk_write_cause: assert property (rx_write |->
    $past(rx_pkt_valid && rx_addr_match && rx_crc_ok && !rx_fifo_full))
    else $error("rx write without a good packet and free slot");
  chk_start_tx: assert property (tx_start |-> enter_tx)
    else $error("start pulse outside transmit mode");
  chk_start_pulse: assert property (tx_start |-> pulse_once)
    else $error("start pulse longer than one cycle");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule
bind rmc_top rmc_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .tx_on(tx_on), .rx_on(rx_on),
  .tx_start(tx_start), .rx_write(rx_write), .rx_pkt_valid(rx_pkt_valid),
  .rx_addr_match(rx_addr_match), .rx_crc_ok(rx_crc_ok), .rx_fifo_full(rx_fifo_full),
  .mode(mode), .s_axi_bvalid(s_axi_bvalid), .s_axi_awready(s_axi_awready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_arready(s_axi_arready));
`default_nettype wire

/* verification/rmc_peer.sv */
// peer modem: finishes each sent packet, then acks it if told to, the packet is not itself an ack, and the device listens
// assumes strobes on sys_clk; latency comes from the bench
`default_nettype none
module rmc_peer (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       tx_start,
  input  wire logic       tx_is_ack,
  input  wire logic       rx_on,
  input  wire logic       ack_en,
  input  wire logic [7:0] lat,
  output logic            tx_done,
  output logic            ack_received
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic [1:0] st_q;
  logic       ack_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      st_q <= 2'h0;
      ack_q <= 1'b0;
      tx_done <= 1'b0;
      ack_received <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      ack_received <= 1'b0;
      if (tx_start) begin
        cnt_q <= lat;
        st_q <= 2'h1;
        ack_q <= ack_en && !tx_is_ack;
      end else if (st_q != 2'h0 && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (st_q == 2'h1) begin
        tx_done <= 1'b1;
        st_q <= ack_q ? 2'h2 : 2'h0;
        cnt_q <= lat;
      end else if (st_q == 2'h2 && rx_on) begin
        // an ack is only heard while the device is still listening
        ack_received <= 1'b1;
        st_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// bench for the radio mode state machine
// drives bus, pins and receive strobes; the peer model answers transmissions
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  logic sys_clk = 0, rstn = 0, ce = 0, sel_n = 1, rf = 0, empty = 1, no_ack = 0;
  logic pv = 0, am = 0, crc = 0, rna = 0, full = 0, ack_en = 0;
  logic tx_done, ack_rx, tx_on, rx_on, tx_start, retx, is_ack, rx_write, irq_n;
  logic [11:0] freq;
  rmc_rate_t air_rate;
  rmc_state_t mode;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int num_errors = 0, checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // short counts keep the ack wait and retry delay inside a brief run
  rmc_top #(.CD_CYC_P(20), .ACK_CYC_P(30), .RSTEP_CYC_P(10)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .radio_activate(ce), .spi_select_n(sel_n),
    .rf_signal(rf), .tx_fifo_empty(empty), .tx_no_ack(no_ack), .tx_done(tx_done),
    .ack_received(ack_rx), .rx_pkt_valid(pv), .rx_addr_match(am), .rx_crc_ok(crc),
    .rx_no_ack(rna), .rx_fifo_full(full), .tx_on(tx_on), .rx_on(rx_on),
    .tx_start(tx_start), .tx_retransmit(retx), .tx_is_ack(is_ack), .rx_write(rx_write),
    .carrier_freq_mhz(freq), .air_rate(air_rate), .mode(mode), .irq_n(irq_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rmc_peer peer (.sys_clk(sys_clk), .rstn(rstn), .tx_start(tx_start), .tx_is_ack(is_ack),
    .rx_on(rx_on), .ack_en(ack_en), .lat(8'h06), .tx_done(tx_done), .ack_received(ack_rx));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
          input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata & m, e);
    chk("rresp", rresp, er);
  endtask
  task wait_mode(input rmc_state_t m);
    for (int i = 0; i < 300 && mode !== m; i++) @(posedge sys_clk);
    chk("mode", mode, m);
  endtask
  task wait_start;
    tick(1);
    for (int i = 0; i < 300 && tx_start !== 1'b1; i++) @(posedge sys_clk);
    chk("tx_start", tx_start, 1'b1);
  endtask
  // one received packet; write strobe and start pulse land one cycle after it
  task pkt(input logic good, input logic ew, input logic es);
    @(posedge sys_clk);
    pv <= 1'b1;
    am <= 1'b1;
    crc <= good;
    @(posedge sys_clk);
    pv <= 1'b0;
    am <= 1'b0;
    crc <= 1'b0;
    @(posedge sys_clk);
    chk("rx_write", rx_write, ew);
    chk("start_ack", {tx_start, is_ack & es}, {es, es});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(OFF_CTRL, '1, 32'h04, RESP_OKAY);
    rd(OFF_RETRY, '1, 32'h03, RESP_OKAY);
    rd(OFF_CHANNEL, '1, 32'h02, RESP_OKAY);
    rd(OFF_MASK, '1, 32'h00, RESP_OKAY);
    rd(8'h1c, '1, 32'h00, RESP_SLVERR);
    wr(OFF_STATUS, 32'h07, RESP_SLVERR);
    chk("freq", freq, 12'h962);
    wr(OFF_CHANNEL, 32'h7f, RESP_OKAY);
    tick(2);
    chk("freq", freq, 12'h9df);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CTRL, (i == 1) ? 32'h14 : (i == 2) ? 32'h0c : 32'h04, RESP_OKAY);
      tick(2);
      chk("air_rate", air_rate, i);
    end
    chk("mode", mode, RMC_PWR_DOWN);
  endtask
  task t_tx;
    wr(OFF_CTRL, 32'h01, RESP_OKAY);
    wait_mode(RMC_STBY1);
    empty <= 1'b0;
    ce <= 1'b1;
    wait_start();
    chk("retx_ack", {retx, is_ack}, 2'b00);
    empty <= 1'b1;
    wait_mode(RMC_STBY2);
    rd(OFF_FLAGS, '1, 32'h01, RESP_OKAY);
    chk("irq_n", irq_n, 1'b0);
    wr(OFF_MASK, 32'h01, RESP_OKAY);
    tick(2);
    chk("irq_n", irq_n, 1'b1);
    wr(OFF_MASK, 32'h00, RESP_OKAY);
    wr(OFF_FLAGS, 32'h01, RESP_OKAY);
    tick(2);
    chk("irq_n", irq_n, 1'b1);
    empty <= 1'b0;
    wait_start();
    wait_start();
    chk("mode", mode, RMC_TX);
    ce <= 1'b0;
    empty <= 1'b1;
    tick(3);
    chk("mode", mode, RMC_TX);
    wait_mode(RMC_STBY1);
  endtask
  task t_ack;
    time t0;
    wr(OFF_CTRL, 32'h05, RESP_OKAY);
    ack_en <= 1'b1;
    ce <= 1'b1;
    empty <= 1'b0;
    wait_start();
    empty <= 1'b1;
    wait_mode(RMC_RX);
    wait_mode(RMC_STBY2);
    ack_en <= 1'b0;
    empty <= 1'b0;
    wait_start();
    empty <= 1'b1;
    ack_en <= 1'b1;
    wait_mode(RMC_STBY1);
    t0 = $time;
    wait_start();
    // one retry step of 10 cycles; the mode output shows standby one cycle late
    chk("retry_gap", 32'(($time - t0) / 10), 32'h9);
    chk("retx", retx, 1'b1);
    wait_mode(RMC_STBY2);
    ce <= 1'b0;
    wait_mode(RMC_STBY1);
    rd(OFF_STATUS, 32'h78, 32'h08, RESP_OKAY);
  endtask
  task t_rx;
    wr(OFF_CTRL, 32'h03, RESP_OKAY);
    ce <= 1'b1;
    wait_mode(RMC_RX);
    pkt(1'b0, 1'b0, 1'b0);
    pkt(1'b1, 1'b1, 1'b0);
    full <= 1'b1;
    pkt(1'b1, 1'b0, 1'b0);
    full <= 1'b0;
    rd(OFF_DROPS, '1, 32'h01, RESP_OKAY);
    chk("mode", mode, RMC_RX);
    wr(OFF_CTRL, 32'h07, RESP_OKAY);
    rna <= 1'b1;
    pkt(1'b1, 1'b1, 1'b0);
    rna <= 1'b0;
    pkt(1'b1, 1'b1, 1'b1);
    wait_mode(RMC_TX);
    wait_mode(RMC_RX);
    rf <= 1'b1;
    tick(10);
    rd(OFF_STATUS, 32'h80, 32'h00, RESP_OKAY);
    sel_n <= 1'b0;
    tick(20);
    rd(OFF_STATUS, 32'h187, 32'h184, RESP_OKAY);
    rf <= 1'b0;
    ce <= 1'b0;
    wait_mode(RMC_STBY1);
    wr(OFF_CTRL, 32'h00, RESP_OKAY);
    wait_mode(RMC_PWR_DOWN);
    rd(OFF_CHANNEL, '1, 32'h7f, RESP_OKAY);
  endtask
  task give_verdict;
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(6);
    rstn <= 1'b1;
    t_regs();
    t_tx();
    t_ack();
    t_rx();
    give_verdict();
  end
  initial begin
    tick(20000);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
